// [rtl/link_sync.sv]
`timescale 1ns/1ns
module link_sync #(
	parameter logic INIT = 1'b1
) (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic async_in,
	output logic level_out,
	output logic rise_out,
	output logic fall_out
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// meta_q feeds sync_q only
	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			meta_q <= INIT;
			sync_q <= INIT;
			prev_q <= INIT;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level_out = sync_q;
	assign rise_out = sync_q & ~prev_q;
	assign fall_out = ~sync_q & prev_q;
endmodule // link_sync

// [rtl/sar_dev_end.sv]
`timescale 1ns/1ns
`include "sar_port_defines.svh"
module sar_dev_end #(
	parameter int unsigned PWRUP_CYC = `PWRUP_CYC
) (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	sar_link_if.dev link,
	input wire sar_port_pkg::result_t sample_in,
	output logic hold_out,
	output logic sleep_out,
	output logic soft_reset_out
);
	import sar_port_pkg::*;

	// ------------------------------------------------------------
	// pin sampling
	// ------------------------------------------------------------
	logic cnv_lvl, cnv_rise, cnv_fall;
	logic cs_lvl, cs_rise, cs_fall;
	logic sclk_fall;

	link_sync u_cnv (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.async_in(link.conversion_start_n), .level_out(cnv_lvl),
		.rise_out(cnv_rise), .fall_out(cnv_fall));
	link_sync u_cs (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.async_in(link.cs_n), .level_out(cs_lvl),
		.rise_out(cs_rise), .fall_out(cs_fall));
	// sclk idles low, so a high reset value would fake a fall after reset
	link_sync #(.INIT(1'b0)) u_sclk (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.async_in(link.sclk), .level_out(),
		.rise_out(), .fall_out(sclk_fall));

	// ------------------------------------------------------------
	// conversion and power sequencing
	// ------------------------------------------------------------
	dev_state_t state_q;
	tmr_t tmr_q;
	result_t sample_q;
	result_t shift_q;
	cnt_t fcnt_q;
	logic oe_q, sdo_q, busy_en_q, frame_q, srst_arm_q;

	wire conv_start = cnv_fall && state_q == DEV_IDLE;
	wire conv_end = state_q == DEV_CONV && tmr_q == tmr_t'(`CONV_CYC - 1);
	wire wake_done = state_q == DEV_WAKE && tmr_q == tmr_t'(PWRUP_CYC - 1);
	wire cnt_t last_fall = busy_en_q ? cnt_t'(`CLKS_BUSY) : cnt_t'(`CLKS_PLAIN);
	wire cnt_t fcnt_inc = fcnt_q + cnt_t'(1);
	wire short_read = frame_q && fcnt_q >= cnt_t'(`SRST_FIRST) &&
		fcnt_q <= cnt_t'(`SRST_LAST);

	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			state_q <= DEV_IDLE;
			tmr_q <= '0;
			sample_q <= '0;
		end
		else
		begin
			unique case (state_q)
				DEV_IDLE:
				begin
					tmr_q <= '0;
					if (conv_start)
					begin
						state_q <= DEV_CONV;
						sample_q <= sample_in;
					end
				end
				DEV_CONV:
				begin
					tmr_q <= tmr_q + tmr_t'(1);
					if (conv_end)
						state_q <= cnv_lvl ? DEV_IDLE : DEV_SLEEP;
				end
				DEV_SLEEP:
				begin
					tmr_q <= '0;
					if (cnv_rise)
						state_q <= DEV_WAKE;
				end
				DEV_WAKE:
				begin
					tmr_q <= tmr_q + tmr_t'(1);
					if (wake_done)
						state_q <= DEV_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// serial readout, alive in every power state
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			shift_q <= '0;
			fcnt_q <= '0;
			oe_q <= 1'b0;
			sdo_q <= 1'b0;
			busy_en_q <= 1'b0;
			frame_q <= 1'b0;
			srst_arm_q <= 1'b0;
			soft_reset_out <= 1'b0;
		end
		else
		begin
			soft_reset_out <= 1'b0;
			if (conv_end)
			begin
				shift_q <= sample_q;
				fcnt_q <= '0;
				busy_en_q <= !cs_lvl;
				frame_q <= !cs_lvl;
				oe_q <= !cs_lvl;
				sdo_q <= 1'b0;
				if (srst_arm_q)
				begin
					srst_arm_q <= 1'b0;
					soft_reset_out <= 1'b1;
				end
			end
			else if (cs_rise)
			begin
				oe_q <= 1'b0;
				frame_q <= 1'b0;
			end
			// no drive while converting, so a stale low never fakes the busy end;
			// a busy frame lowers select together with the start pin
			else if (cs_fall && state_q != DEV_CONV && !conv_start)
			begin
				oe_q <= 1'b1;
				sdo_q <= shift_q[`RES_BITS-1];
				shift_q <= {shift_q[`RES_BITS-2:0], 1'b0};
				busy_en_q <= 1'b0;
				frame_q <= 1'b1;
				fcnt_q <= '0;
			end
			else if (sclk_fall && frame_q)
			begin
				if (fcnt_q != '1)
					fcnt_q <= fcnt_inc;
				if (fcnt_inc == last_fall)
					oe_q <= 1'b0;
				else if (fcnt_inc < last_fall)
				begin
					sdo_q <= shift_q[`RES_BITS-1];
					shift_q <= {shift_q[`RES_BITS-2:0], 1'b0};
				end
			end
			// arming after the clear lets a new arm win over the clear
			if (cs_rise && short_read)
				srst_arm_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			hold_out <= 1'b0;
			sleep_out <= 1'b0;
		end
		else
		begin
			hold_out <= conv_start || (state_q == DEV_CONV && !conv_end);
			sleep_out <= state_q == DEV_SLEEP || state_q == DEV_WAKE;
		end
	end

	assign link.sdo_o = sdo_q;
	assign link.sdo_oe = oe_q;
endmodule // sar_dev_end

// [rtl/sar_host_end.sv]
`timescale 1ns/1ns
`include "sar_port_defines.svh"
module sar_host_end #(
	parameter int unsigned PWRUP_CYC = `PWRUP_CYC
) (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	sar_link_if.host link,
	input wire logic start_in,
	input wire logic soft_reset_in,
	input wire logic busy_mode_in,
	input wire logic power_down_in,
	input wire logic word16_in,
	input wire sar_port_pkg::chan_t chan_in,
	output sar_port_pkg::chan_t chan_out,
	output sar_port_pkg::result_t result_out,
	output logic result_valid_out,
	output logic ready_out
);
	import sar_port_pkg::*;

	// ------------------------------------------------------------
	// data line sampling
	// ------------------------------------------------------------
	logic sdo_lvl;

	link_sync u_sdo (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.async_in(link.sdo), .level_out(sdo_lvl),
		.rise_out(), .fall_out());

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	host_state_t st_q;
	tmr_t tmr_q;
	cnt_t clk_i_q;
	cnt_t nclk_q;
	result_t res_q;
	logic cnv_n_q, cs_n_q, sclk_q;
	logic busy_q, pd_req_q, word16_q, srst_q, asleep_q;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire half_end = tmr_q == tmr_t'(`SCLK_HALF_CYC - 1);
	wire rise_now = st_q == H_READ && half_end && !sclk_q;
	wire fall_now = st_q == H_READ && half_end && sclk_q;
	wire cnt_t next_idx = clk_i_q + cnt_t'(1);
	wire in_busy_bits = next_idx >= cnt_t'(`BUSY_FIRST_BIT_CLK) &&
		next_idx <= cnt_t'(`CLKS_BUSY);
	wire in_plain_bits = next_idx <= cnt_t'(`CLKS_PLAIN);
	// tail clocks of a 16-clock word land outside both windows
	wire take_bit = rise_now && (busy_q ? in_busy_bits : in_plain_bits);
	wire last_fall = fall_now && clk_i_q == nclk_q;
	wire pwrup_done = tmr_q == tmr_t'(PWRUP_CYC - 1);
	wire mux_done = tmr_q == tmr_t'(`MUX_SETUP_CYC - 1);
	wire hold_done = tmr_q == tmr_t'(`MUX_HOLD_CYC - 1);
	// margin covers pin synchroniser delay inside the converter
	wire conv_done = tmr_q >= tmr_t'(`CONV_CYC + `EOC_MARGIN_CYC);
	wire busy_seen = busy_q && !sdo_lvl;
	wire quiet_done = tmr_q == tmr_t'(`QUIET_CYC - 1);
	wire cnt_t read_len = srst_q ? cnt_t'(`CLKS_SRST) :
		word16_q ? cnt_t'(`CLKS_WORD16) :
		busy_q ? cnt_t'(`CLKS_BUSY) : cnt_t'(`CLKS_PLAIN);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			st_q <= H_PWRUP;
			tmr_q <= '0;
			cnv_n_q <= 1'b1;
			cs_n_q <= 1'b1;
			srst_q <= 1'b1;
			asleep_q <= 1'b0;
			busy_q <= 1'b0;
			pd_req_q <= 1'b0;
			word16_q <= 1'b0;
			chan_out <= '0;
			ready_out <= 1'b0;
			nclk_q <= '0;
		end
		else
		begin
			unique case (st_q)
				H_PWRUP:
				begin
					tmr_q <= tmr_q + tmr_t'(1);
					if (pwrup_done)
					begin
						tmr_q <= '0;
						st_q <= H_MUX;
					end
				end
				H_IDLE:
				begin
					tmr_q <= '0;
					cs_n_q <= 1'b1;
					if (soft_reset_in || start_in)
					begin
						ready_out <= 1'b0;
						srst_q <= soft_reset_in;
						busy_q <= busy_mode_in && !soft_reset_in;
						pd_req_q <= power_down_in && !soft_reset_in;
						word16_q <= word16_in && !soft_reset_in;
						if (!soft_reset_in)
							chan_out <= chan_in;
						if (asleep_q)
						begin
							cnv_n_q <= 1'b1;
							asleep_q <= 1'b0;
							st_q <= H_PWRUP;
						end
						else
							st_q <= H_MUX;
					end
				end
				H_MUX:
				begin
					tmr_q <= tmr_q + tmr_t'(1);
					if (mux_done)
					begin
						tmr_q <= '0;
						nclk_q <= read_len;
						cnv_n_q <= 1'b0;
						cs_n_q <= !busy_q;
						st_q <= H_CONV;
					end
				end
				H_CONV:
				begin
					tmr_q <= tmr_q + tmr_t'(1);
					if (hold_done)
					begin
						if (!pd_req_q)
							cnv_n_q <= 1'b1;
						st_q <= H_EOC;
					end
				end
				H_EOC:
				begin
					tmr_q <= tmr_q + tmr_t'(1);
					if (busy_q ? busy_seen : conv_done)
					begin
						tmr_q <= '0;
						cs_n_q <= 1'b0;
						st_q <= H_READ;
					end
				end
				H_READ:
				begin
					tmr_q <= half_end ? '0 : tmr_q + tmr_t'(1);
					if (last_fall)
						st_q <= H_TAIL;
				end
				H_TAIL:
				begin
					tmr_q <= tmr_q + tmr_t'(1);
					if (half_end)
					begin
						tmr_q <= '0;
						cs_n_q <= 1'b1;
						asleep_q <= !cnv_n_q;
						srst_q <= 1'b0;
						st_q <= H_QUIET;
					end
				end
				H_QUIET:
				begin
					tmr_q <= tmr_q + tmr_t'(1);
					if (quiet_done)
					begin
						ready_out <= 1'b1;
						st_q <= H_IDLE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// serial clock burst and result capture
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			sclk_q <= 1'b0;
			clk_i_q <= '0;
			res_q <= '0;
			result_out <= '0;
			result_valid_out <= 1'b0;
		end
		else
		begin
			result_valid_out <= 1'b0;
			if (st_q != H_READ)
			begin
				sclk_q <= 1'b0;
				clk_i_q <= '0;
			end
			else if (half_end)
				sclk_q <= !sclk_q;
			if (rise_now)
				clk_i_q <= next_idx;
			if (take_bit)
				res_q <= {res_q[`RES_BITS-2:0], sdo_lvl};
			if (st_q == H_TAIL && half_end && !srst_q)
			begin
				result_out <= res_q;
				result_valid_out <= 1'b1;
			end
		end
	end

	assign link.conversion_start_n = cnv_n_q;
	assign link.cs_n = cs_n_q;
	assign link.sclk = sclk_q;
endmodule // sar_host_end

// [rtl/sar_link_if.sv]
`timescale 1ns/1ns
interface sar_link_if;
	logic conversion_start_n;
	logic cs_n;
	logic sclk;
	logic sdo_o;
	logic sdo_oe;
	logic sdo;

	// released line reads high through the pull-up
	assign sdo = sdo_oe ? sdo_o : 1'b1;

	modport dev (
		input conversion_start_n,
		input cs_n,
		input sclk,
		output sdo_o,
		output sdo_oe
	);
	modport host (
		output conversion_start_n,
		output cs_n,
		output sclk,
		input sdo
	);
endinterface

// [rtl/sar_port_defines.svh]
`ifndef SAR_PORT_DEFINES_SVH
`define SAR_PORT_DEFINES_SVH

// ------------------------------------------------------------
// clock and time conversion
// ------------------------------------------------------------
`define CLK_NS 8
`define CYC_CEIL(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)

// ------------------------------------------------------------
// converter timing
// ------------------------------------------------------------
`define CONV_NS 650
`define CONV_CYC `CYC_CEIL(`CONV_NS)
`define PWRUP_US 100
`define PWRUP_CYC `CYC_CEIL(`PWRUP_US * 1000)
`define MUX_SETUP_NS 350
`define MUX_SETUP_CYC `CYC_CEIL(`MUX_SETUP_NS)
`define MUX_HOLD_NS 200
`define MUX_HOLD_CYC `CYC_CEIL(`MUX_HOLD_NS)
`define QUIET_NS 50
`define QUIET_CYC `CYC_CEIL(`QUIET_NS)
`define EOC_MARGIN_CYC 8
`define SCLK_HALF_CYC 10

// ------------------------------------------------------------
// frame geometry
// ------------------------------------------------------------
`define RES_BITS 12
`define CLKS_PLAIN 12
`define CLKS_BUSY 13
`define CLKS_WORD16 16
`define CLKS_SRST 8
`define BUSY_FIRST_BIT_CLK 2
`define SRST_FIRST 2
`define SRST_LAST 8
`define TMR_W 16
`define CNT_W 5
`define CH_W 3

`endif

// [rtl/sar_port_pkg.sv]
`include "sar_port_defines.svh"
package sar_port_pkg;
	typedef logic [`RES_BITS-1:0] result_t;
	typedef logic [`TMR_W-1:0] tmr_t;
	typedef logic [`CNT_W-1:0] cnt_t;
	typedef logic [`CH_W-1:0] chan_t;
	typedef enum logic [1:0] {DEV_IDLE, DEV_CONV, DEV_SLEEP, DEV_WAKE} dev_state_t;
	typedef enum logic [2:0] {H_PWRUP, H_IDLE, H_MUX, H_CONV, H_EOC, H_READ, H_TAIL, H_QUIET}
		host_state_t;
endpackage

// [verification/sar_adc_serial_conversion_port_test.sv]
`timescale 1ns/1ns
`include "sar_port_defines.svh"
module sar_adc_serial_conversion_port_test;
	import sar_port_pkg::*;
	logic sys_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic start_in = 1'b0;
	logic soft_reset_in = 1'b0;
	logic busy_mode_in = 1'b0;
	logic power_down_in = 1'b0;
	logic word16_in = 1'b0;
	chan_t chan_in = 3'h0;
	chan_t chan_out;
	result_t sample_in = 12'h000;
	result_t result_out;
	logic result_valid_out, ready_out, hold_out, sleep_out, soft_reset_out;
	int errors = 0;
	int checks_done = 0;
	int hold_len = 0;
	int valids = 0;
	int srst_seen = 0;
	result_t exp_q[$];

	sar_link_if link ();
	sar_dev_end #(.PWRUP_CYC(50)) i_sar_dev_end (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.link(link.dev), .sample_in(sample_in), .hold_out(hold_out), .sleep_out(sleep_out),
		.soft_reset_out(soft_reset_out));
	sar_host_end #(.PWRUP_CYC(50)) i_sar_host_end (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.link(link.host), .start_in(start_in), .soft_reset_in(soft_reset_in),
		.busy_mode_in(busy_mode_in), .power_down_in(power_down_in), .word16_in(word16_in),
		.chan_in(chan_in), .chan_out(chan_out), .result_out(result_out),
		.result_valid_out(result_valid_out), .ready_out(ready_out));
	sar_port_monitor i_sar_port_monitor (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.conversion_start_n(link.conversion_start_n), .cs_n(link.cs_n), .sclk(link.sclk),
		.sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe), .sdo(link.sdo));

	always #4 sys_clk_in = ~sys_clk_in;

	// ------------------------------------------------------------
	// compare and verdict
	// ------------------------------------------------------------
	task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic results;
		if (errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------
	// reference model: word order and hold length
	// ------------------------------------------------------------
	// sampled on the falling edge, where registered outputs have settled
	always @(negedge sys_clk_in)
	begin
		if (result_valid_out === 1'b1)
		begin
			valids++;
			if (exp_q.size() > 0)
				check_val("result", 16'(exp_q.pop_front()), 16'(result_out));
			else
				check_val("extra valid", 16'h0000, 16'h0001);
		end
		if (soft_reset_out === 1'b1)
			srst_seen++;
		if (hold_out === 1'b1)
			hold_len++;
		else if (hold_len != 0)
		begin
			check_val("hold length", 16'(`CONV_CYC), 16'(hold_len));
			hold_len = 0;
		end
	end

	// ------------------------------------------------------------
	// host user side drivers
	// ------------------------------------------------------------
	task automatic wait_ready;
		int n;
		n = 0;
		do
		begin
			@(posedge sys_clk_in);
			#1;
			n++;
		end
		while (ready_out !== 1'b1 && n < 20000);
		if (n >= 20000)
		begin
			check_val("ready timeout", 16'h0001, 16'h0000);
			results();
		end
	endtask

	// the second start lands while busy and must vanish
	task automatic run(input bit sr, input bit bm, input bit pd, input bit w16);
		chan_t ch;
		ch = chan_t'($urandom);
		wait_ready();
		sample_in = result_t'($urandom);
		start_in = !sr;
		soft_reset_in = sr;
		busy_mode_in = bm;
		power_down_in = pd;
		word16_in = w16;
		chan_in = ch;
		if (!sr)
			exp_q.push_back(sample_in);
		@(posedge sys_clk_in);
		#1;
		soft_reset_in = 1'b0;
		start_in = 1'b1;
		@(posedge sys_clk_in);
		#1;
		start_in = 1'b0;
		if (!sr)
			check_val("channel", 16'(ch), 16'(chan_out));
	endtask

	initial
	begin
		int starts;
		starts = 0;
		void'($urandom(42807));
		repeat (10) @(posedge sys_clk_in);
		#1;
		nrst_in = 1'b1;
		for (int i = 0; i < 10; i++)
		begin
			run(i == 6, i[0], i == 3, i[1]);
			if (i != 6)
				starts++;
			if (i == 3 || i == 4)
			begin
				wait_ready();
				check_val("sleep", 16'(i == 3), 16'(sleep_out));
			end
		end
		wait_ready();
		check_val("valid count", 16'(starts), 16'(valids));
		check_val("soft resets", 16'h0002, 16'(srst_seen));
		results();
	end

	// ------------------------------------------------------------
	// watchdog: ten frames need well under 10000 cycles
	// ------------------------------------------------------------
	initial
	begin
		#(40000 * 8);
		errors++;
		results();
	end
endmodule // sar_adc_serial_conversion_port_test

// [verification/sar_port_monitor.sv]
`timescale 1ns/1ns
module sar_port_monitor (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic conversion_start_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	input wire logic sdo
);
	// ------------------------------------------------------------
	// link checks
	// ------------------------------------------------------------
	default clocking mon_cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!nrst_in);

	// busy frame: select low in the cycle the start falls or the one after
	sequence busy_start;
		$fell(conversion_start_n) ##[0:1] !cs_n;
	endsequence
	sequence busy_flag;
		sdo_oe && !sdo;
	endsequence

	a_sclk_idle_low: assert property (cs_n |-> !sclk)
		else $error("serial clock active outside a frame");
	a_cs_rise_release: assert property ($rose(cs_n) |-> ##[1:6] !sdo_oe)
		else $error("data not released after select rise");
	a_idle_released: assert property (cs_n [*8] |-> !sdo_oe)
		else $error("data driven while deselected");
	a_plain_drive: assert property ($fell(cs_n) && conversion_start_n |-> ##[1:6] sdo_oe)
		else $error("select fall did not drive data");
	a_busy_low_eoc: assert property (busy_start |-> ##[75:100] busy_flag)
		else $error("busy low missing at conversion end");
	a_start_hold: assert property ($fell(conversion_start_n) |-> ##24 !conversion_start_n)
		else $error("start released too early");
	a_change_on_fall: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo_o) |-> !sclk)
		else $error("data changed while serial clock high");
	a_sclk_half_min: assert property ($changed(sclk) |=> $stable(sclk) [*8])
		else $error("serial clock half period too short");
	c_busy_frame: cover property (busy_start);
endmodule // sar_port_monitor
